/* verilog/dbvx_pkg.sv */
// constants, carrier types and states for the variable exchange block
// How it works
// (RULE1) In single-user mode the device sets bit 0 of the ready word after a refresh and the host clears it to ask for another.
// (RULE2) The servo timer word is written at the moment the ready word is raised; the code writes it one cycle before the ready word.
// (RULE3) The host gives the descriptor list length as a count of 32-bit entries.
// (RULE4) The host keeps the descriptor list start between D200h and DFFDh.
// (RULE5) In multi-user mode the host clears descriptor bit 15 to ask for a fresh value.
// (RULE6) In multi-user mode the device sets descriptor bit 15 once that value is placed.
// (RULE7) Descriptor type 0 reads a Y word, 1 a long pair, 2 an X word, 4 a special block; 0 and 2 return 32 bits, 1 and 4 return 64.
// (RULE8) For the special type the second word is a block number offset from a base kept at a fixed location.
// (RULE9) The host sets the write flag to ask for an update and the device clears it when done.
// (RULE10) The host places the write structure between D240h and DFFDh and writes its address to the start word.
// (RULE11) Write entry bits 13 to 15 are the special type, 0 a compiled function block, the rest reserved.
// (RULE12) Write entry bits 8 to 12 give the starting bit offset in the target word.
// (RULE13) Write entry bits 3 to 7 give the field width, 0 meaning all 24 bits.
// (RULE14) Write entry bits 0 to 2 give the target: Y, long, X, special Y or special X.
// (RULE15) Each data item travels as an upper half in the X word and a lower half in the Y word.
// (RULE16) Descriptors are walked in order from the start for exactly the counted number.
package dbvx_pkg;
  // host-side byte offsets of the exchange words
  localparam logic [15:0] HOST_WFLG_OFS  = 16'h07E6;
  localparam logic [15:0] HOST_RDY_OFS   = 16'h07E8;
  localparam logic [15:0] HOST_WSTART_OFS = 16'h07E8;
  localparam logic [15:0] HOST_TIMER_OFS = 16'h07EA;
  localparam logic [15:0] HOST_SIZE_OFS  = 16'h07EC;
  localparam logic [15:0] HOST_LIST_OFS  = 16'h07EE;
  // same words in the controller map: Y holds the first, X the second
  localparam logic [15:0] WFLG_ADR    = 16'hD1F5;
  localparam logic [15:0] RDY_ADR     = 16'hD1FA;
  localparam logic [15:0] LIST_ADR    = 16'hD1FB;
  localparam logic [15:0] FB_BASE_ADR = 16'h9FFF;
  localparam logic [15:0] RDY_VAL     = 16'h0001;
  localparam logic [15:0] MARK_VAL    = 16'h8000;
  localparam int RDY_BIT  = 0;
  localparam int WFLG_BIT = 0;
  localparam int MARK_BIT = 15;
  localparam int TYPE_LSB = 0;
  localparam int WID_LSB  = 3;
  localparam int OFF_LSB  = 8;
  localparam int SPC_LSB  = 13;
  localparam logic [2:0] SPC_FB = 3'h0;
  localparam logic [2:0] T_Y    = 3'h0;
  localparam logic [2:0] T_L    = 3'h1;
  localparam logic [2:0] T_X    = 3'h2;
  localparam logic [2:0] T_SY   = 3'h4;
  localparam logic [2:0] T_SX   = 3'h6;
  localparam logic [4:0] FULL_W = 5'h18;

  typedef struct packed {
    logic [15:0] addr;
    logic        xsel;
    logic        we;
    logic [15:0] wdata;
  } dbvx_dp_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        xsel;
    logic        we;
    logic [23:0] wdata;
  } dbvx_cm_req_t;

  typedef enum logic [4:0] {
    S_IDLE, S_FET, S_WT, S_CAP, S_WCHK, S_WENT, S_WBAS, S_WMOD,
    S_WLNG, S_WLNG2, S_WDONE, S_RCHK, S_RNXT, S_RDSC, S_RBAS,
    S_RV0, S_RV1, S_RV2, S_RPUT, S_RMRK, S_RSKP, S_RDONE, S_RRDY
  } dbvx_state_t;
endpackage

/* verilog/dbvx_exchange.sv */
// controller-side engine for background variable exchange over dual-port ram
`timescale 1ns/1ps
module dbvx_exchange (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 multi_user,
  input  wire logic [15:0]          servo_timer,
  input  wire logic [15:0]          dp_rdata,
  input  wire logic [23:0]          cm_rdata,
  output dbvx_pkg::dbvx_dp_req_t    dp_o,
  output dbvx_pkg::dbvx_cm_req_t    cm_o,
  output logic                      busy
);

  dbvx_pkg::dbvx_state_t state;
  dbvx_pkg::dbvx_state_t ret;
  dbvx_pkg::dbvx_state_t fret;
  logic [15:0]           wbuf [0:5];
  logic [15:0]           fa;
  logic [2:0]            fi;
  logic [2:0]            fn;
  logic                  fy;
  logic [15:0]           rcount;
  logic [15:0]           ri;
  logic [15:0]           rptr;
  logic [15:0]           res;
  logic [15:0]           cadr;
  logic [2:0]            dtype;
  logic [23:0]           v0;
  logic [23:0]           v1;
  logic [1:0]            pi;
  logic [2:0]            wkind;
  logic [4:0]            wwid;
  logic [4:0]            woff;
  logic [31:0]           wd1;
  logic [31:0]           wd2;
  logic [15:0]           tadr;
  logic [23:0]           wmask;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is64(input logic [2:0] t);
    return (t == dbvx_pkg::T_L) || (t == dbvx_pkg::T_SY);
  endfunction

  // width 0 or anything past 24 falls back to the whole word
  function automatic logic [23:0] fmask(input logic [4:0] w,
                                        input logic [4:0] o);
    logic [24:0] m;
    m = 25'h1FFFFFF;
    if (w != 5'h00 && w < dbvx_pkg::FULL_W) begin
      m = (25'h1 << w) - 25'h1;
    end
    return m[23:0] << o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one sequencer: dual-port words and core memory share one ram latency
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= dbvx_pkg::S_IDLE;
      ret    <= dbvx_pkg::S_IDLE;
      fret   <= dbvx_pkg::S_IDLE;
      dp_o   <= '0;
      cm_o   <= '0;
      fa     <= 16'h0000;
      fi     <= 3'h0;
      fn     <= 3'h0;
      fy     <= 1'b0;
      rcount <= 16'h0000;
      ri     <= 16'h0000;
      rptr   <= 16'h0000;
      res    <= 16'h0000;
      cadr   <= 16'h0000;
      dtype  <= 3'h0;
      v0     <= 24'h000000;
      v1     <= 24'h000000;
      pi     <= 2'h0;
      wkind  <= 3'h0;
      wwid   <= 5'h00;
      woff   <= 5'h00;
      wd1    <= 32'h00000000;
      wd2    <= 32'h00000000;
      tadr   <= 16'h0000;
      wmask  <= 24'h000000;
      for (int k = 0; k < 6; k++) begin
        wbuf[k] <= 16'h0000;
      end
    end else begin
      dp_o.we <= 1'b0;
      cm_o.we <= 1'b0;
      case (state)
        dbvx_pkg::S_IDLE: begin
          fa    <= dbvx_pkg::WFLG_ADR;
          fy    <= 1'b1;
          fi    <= 3'h0;
          fn    <= 3'h1;
          fret  <= dbvx_pkg::S_WCHK;
          state <= dbvx_pkg::S_FET;
        end
        // fetch words fi..fn; word i sits at fa+i/2, Y first when fy
        dbvx_pkg::S_FET: begin
          dp_o.addr <= fa + {14'h0000, fi[2:1]};
          dp_o.xsel <= ~(fi[0] ^ fy);
          ret       <= dbvx_pkg::S_CAP;
          state     <= dbvx_pkg::S_WT;
        end
        dbvx_pkg::S_WT: begin
          state <= ret;
        end
        dbvx_pkg::S_CAP: begin
          wbuf[fi] <= dp_rdata;
          if (fi == fn) begin
            state <= fret;
          end else begin
            fi    <= fi + 3'h1;
            state <= dbvx_pkg::S_FET;
          end
        end
        dbvx_pkg::S_WCHK: begin
          fi    <= 3'h0;
          state <= dbvx_pkg::S_FET;
          if (wbuf[0][dbvx_pkg::WFLG_BIT]) begin // RULE9
            fa   <= wbuf[1]; // RULE10
            fy   <= 1'b0;
            fn   <= 3'h5;
            fret <= dbvx_pkg::S_WENT;
          end else begin
            fa   <= dbvx_pkg::RDY_ADR;
            fy   <= 1'b1;
            fn   <= 3'h3;
            fret <= dbvx_pkg::S_RCHK;
          end
        end
        dbvx_pkg::S_WENT: begin
          wkind     <= wbuf[0][dbvx_pkg::TYPE_LSB+:3]; // RULE14
          wwid      <= wbuf[0][dbvx_pkg::WID_LSB+:5]; // RULE13
          woff      <= wbuf[0][dbvx_pkg::OFF_LSB+:5]; // RULE12
          wmask     <= fmask(wbuf[0][dbvx_pkg::WID_LSB+:5],
                             wbuf[0][dbvx_pkg::OFF_LSB+:5]);
          wd1       <= {wbuf[2], wbuf[3]}; // RULE15
          wd2       <= {wbuf[4], wbuf[5]};
          tadr      <= wbuf[1];
          cm_o.addr <= wbuf[1];
          cm_o.xsel <= wbuf[0][1];
          if (wbuf[0][dbvx_pkg::SPC_LSB+:3] != dbvx_pkg::SPC_FB) begin
            state <= dbvx_pkg::S_WDONE; // RULE11
          end else begin
            case (wbuf[0][dbvx_pkg::TYPE_LSB+:3]) // RULE14
              dbvx_pkg::T_Y, dbvx_pkg::T_X: begin
                ret   <= dbvx_pkg::S_WMOD;
                state <= dbvx_pkg::S_WT;
              end
              dbvx_pkg::T_L: begin
                state <= dbvx_pkg::S_WLNG;
              end
              dbvx_pkg::T_SY, dbvx_pkg::T_SX: begin
                cm_o.addr <= dbvx_pkg::FB_BASE_ADR;
                cm_o.xsel <= 1'b0;
                ret       <= dbvx_pkg::S_WBAS;
                state     <= dbvx_pkg::S_WT;
              end
              default: begin
                state <= dbvx_pkg::S_WDONE;
              end
            endcase
          end
        end
        dbvx_pkg::S_WBAS: begin
          cm_o.addr <= cm_rdata[15:0] + tadr;
          cm_o.xsel <= wkind[1];
          ret       <= dbvx_pkg::S_WMOD;
          state     <= dbvx_pkg::S_WT;
        end
        // read-modify-write keeps bits outside the field untouched
        dbvx_pkg::S_WMOD: begin
          cm_o.we    <= 1'b1;
          cm_o.wdata <= (cm_rdata & ~wmask)
                        | (wmask & (wd1[23:0] << woff)); // RULE12 RULE13
          state      <= dbvx_pkg::S_WDONE;
        end
        dbvx_pkg::S_WLNG: begin
          cm_o.addr  <= tadr;
          cm_o.xsel  <= 1'b0;
          cm_o.we    <= 1'b1;
          cm_o.wdata <= wd1[23:0];
          state      <= dbvx_pkg::S_WLNG2;
        end
        dbvx_pkg::S_WLNG2: begin
          cm_o.xsel  <= 1'b1;
          cm_o.we    <= 1'b1;
          cm_o.wdata <= wd2[23:0];
          state      <= dbvx_pkg::S_WDONE;
        end
        dbvx_pkg::S_WDONE: begin
          dp_o.addr  <= dbvx_pkg::WFLG_ADR; // RULE9
          dp_o.xsel  <= 1'b0;
          dp_o.we    <= 1'b1;
          dp_o.wdata <= 16'h0000;
          state      <= dbvx_pkg::S_IDLE;
        end
        dbvx_pkg::S_RCHK: begin
          rcount <= wbuf[2]; // RULE3
          rptr   <= wbuf[3]; // RULE4
          res    <= wbuf[3] + wbuf[2];
          ri     <= 16'h0000;
          if (multi_user || !wbuf[0][dbvx_pkg::RDY_BIT]) begin // RULE1
            state <= dbvx_pkg::S_RNXT;
          end else begin
            state <= dbvx_pkg::S_IDLE;
          end
        end
        dbvx_pkg::S_RNXT: begin
          fa   <= rptr;
          fy   <= 1'b0;
          fi   <= 3'h0;
          fn   <= 3'h1;
          fret <= dbvx_pkg::S_RDSC;
          if (ri == rcount) begin // RULE16
            state <= multi_user ? dbvx_pkg::S_IDLE : dbvx_pkg::S_RDONE;
          end else begin
            state <= dbvx_pkg::S_FET;
          end
        end
        dbvx_pkg::S_RDSC: begin
          dtype <= wbuf[0][2:0];
          cadr  <= wbuf[1];
          if ((multi_user && wbuf[0][dbvx_pkg::MARK_BIT]) // RULE5
              || wbuf[0][2:0] == 3'h3 || wbuf[0][2:0] > 3'h4) begin
            state <= dbvx_pkg::S_RSKP;
          end else if (wbuf[0][2:0] == dbvx_pkg::T_SY) begin
            cm_o.addr <= dbvx_pkg::FB_BASE_ADR; // RULE8
            cm_o.xsel <= 1'b0;
            ret       <= dbvx_pkg::S_RBAS;
            state     <= dbvx_pkg::S_WT;
          end else begin
            state <= dbvx_pkg::S_RV0;
          end
        end
        dbvx_pkg::S_RBAS: begin
          cadr  <= cm_rdata[15:0] + cadr; // RULE8
          state <= dbvx_pkg::S_RV0;
        end
        dbvx_pkg::S_RV0: begin
          cm_o.addr <= cadr;
          cm_o.xsel <= (dtype == dbvx_pkg::T_X); // RULE7
          ret       <= dbvx_pkg::S_RV1;
          state     <= dbvx_pkg::S_WT;
        end
        dbvx_pkg::S_RV1: begin
          v0 <= cm_rdata;
          v1 <= 24'h000000;
          pi <= 2'h0;
          if (is64(dtype)) begin // RULE7
            cm_o.xsel <= 1'b1;
            ret       <= dbvx_pkg::S_RV2;
            state     <= dbvx_pkg::S_WT;
          end else begin
            state <= dbvx_pkg::S_RPUT;
          end
        end
        dbvx_pkg::S_RV2: begin
          v1    <= cm_rdata;
          state <= dbvx_pkg::S_RPUT;
        end
        // upper half to X, lower half to Y, one address per 32 bits
        dbvx_pkg::S_RPUT: begin
          dp_o.we   <= 1'b1;
          dp_o.addr <= res + {15'h0000, pi[1]};
          dp_o.xsel <= ~pi[0];
          case (pi)
            2'h0:    dp_o.wdata <= {8'h00, v0[23:16]};
            2'h1:    dp_o.wdata <= v0[15:0];
            2'h2:    dp_o.wdata <= {8'h00, v1[23:16]};
            default: dp_o.wdata <= v1[15:0];
          endcase
          pi <= pi + 2'h1;
          if (pi == (is64(dtype) ? 2'h3 : 2'h1)) begin // RULE7
            state <= multi_user ? dbvx_pkg::S_RMRK : dbvx_pkg::S_RSKP;
          end
        end
        dbvx_pkg::S_RMRK: begin
          dp_o.we    <= 1'b1;
          dp_o.addr  <= rptr;
          dp_o.xsel  <= 1'b1;
          dp_o.wdata <= wbuf[0] | dbvx_pkg::MARK_VAL; // RULE6
          state      <= dbvx_pkg::S_RSKP;
        end
        // skipped descriptors keep their result slot so results stay aligned
        dbvx_pkg::S_RSKP: begin
          rptr  <= rptr + 16'h0001; // RULE16
          ri    <= ri + 16'h0001;
          res   <= res + (is64(dtype) ? 16'h0002 : 16'h0001);
          state <= dbvx_pkg::S_RNXT;
        end
        dbvx_pkg::S_RDONE: begin
          dp_o.we    <= 1'b1;
          dp_o.addr  <= dbvx_pkg::RDY_ADR;
          dp_o.xsel  <= 1'b1;
          dp_o.wdata <= servo_timer; // RULE2
          state      <= dbvx_pkg::S_RRDY;
        end
        dbvx_pkg::S_RRDY: begin
          dp_o.we    <= 1'b1;
          dp_o.xsel  <= 1'b0;
          dp_o.wdata <= dbvx_pkg::RDY_VAL; // RULE1
          state      <= dbvx_pkg::S_IDLE;
        end
        default: begin
          state <= dbvx_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != dbvx_pkg::S_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_timer_then_ready: assert property ( // RULE2
    (dp_o.we && !dp_o.xsel && dp_o.addr == dbvx_pkg::RDY_ADR)
    |-> $past(dp_o.we) && $past(dp_o.xsel)
    && $past(dp_o.addr) == dbvx_pkg::RDY_ADR)
    else $error("ready raised without timer write");
  chk_timer_value: assert property ( // RULE2
    (state == dbvx_pkg::S_RDONE) |=> dp_o.wdata == $past(servo_timer))
    else $error("timer word differs from servo timer");
  chk_ready_value: assert property ( // RULE1
    (dp_o.we && !dp_o.xsel && dp_o.addr == dbvx_pkg::RDY_ADR)
    |-> dp_o.wdata == dbvx_pkg::RDY_VAL && !$past(multi_user, 2))
    else $error("ready word bad value or mode");
  chk_flag_clear: assert property ( // RULE9
    (state == dbvx_pkg::S_WDONE) |=> dp_o.we && !dp_o.xsel
    && dp_o.addr == dbvx_pkg::WFLG_ADR && dp_o.wdata == 16'h0000)
    else $error("write flag not cleared");
  chk_mark_set: assert property ( // RULE6
    (state == dbvx_pkg::S_RMRK) |=> dp_o.we && dp_o.xsel
    && dp_o.wdata[15] && dp_o.addr == $past(rptr))
    else $error("descriptor mark not set");
  chk_fb_base: assert property ( // RULE8
    (state == dbvx_pkg::S_RBAS || state == dbvx_pkg::S_WBAS)
    |-> cm_o.addr == dbvx_pkg::FB_BASE_ADR && !cm_o.xsel)
    else $error("block base not read");
  chk_short_put: assert property ( // RULE7
    (state == dbvx_pkg::S_RPUT && pi == 2'h0 && !is64(dtype))
    |=> state == dbvx_pkg::S_RPUT ##1 state != dbvx_pkg::S_RPUT)
    else $error("32-bit value not two words");
  chk_long_put: assert property ( // RULE7
    (state == dbvx_pkg::S_RPUT && pi == 2'h0 && is64(dtype))
    |=> (state == dbvx_pkg::S_RPUT)[*3] ##1 state != dbvx_pkg::S_RPUT)
    else $error("64-bit value not four words");
  chk_reserved_skip: assert property ( // RULE11
    (state == dbvx_pkg::S_WENT && wbuf[0][15:13] != 3'h0)
    |=> state == dbvx_pkg::S_WDONE)
    else $error("reserved entry applied");
  chk_field_merge: assert property ( // RULE12
    (state == dbvx_pkg::S_WMOD) |=> cm_o.we
    && ((cm_o.wdata ^ $past(cm_rdata)) & ~$past(wmask)) == 24'h000000)
    else $error("bits outside field changed");
  chk_full_width: assert property ( // RULE13
    (state == dbvx_pkg::S_WMOD && wwid == 5'h00 && woff == 5'h00)
    |=> cm_o.wdata == wd1[23:0])
    else $error("full width write wrong");
  chk_kind_space: assert property ( // RULE14
    (state == dbvx_pkg::S_WMOD) |=> cm_o.xsel == wkind[1])
    else $error("write went to wrong space");
  chk_count_bound: assert property ( // RULE16
    (state == dbvx_pkg::S_RSKP) |-> ri < rcount)
    else $error("descriptor past count");

  cov_refresh_done: cover property (state == dbvx_pkg::S_RRDY);
  cov_write_done: cover property (state == dbvx_pkg::S_WDONE);
  cov_multi_mark: cover property (state == dbvx_pkg::S_RMRK);
  cov_special_read: cover property (state == dbvx_pkg::S_RBAS);

endmodule

/* tb/dbvx_host_model.sv */
// host-side model: dual-port ram and controller memory, two-edge reads
`timescale 1ns/1ps
module dbvx_host_model (
  input  wire dbvx_pkg::dbvx_dp_req_t dp_i,
  input  wire dbvx_pkg::dbvx_cm_req_t cm_i,
  input  wire logic                   core_clk,
  output logic [15:0]                 dp_rdata,
  output logic [23:0]                 cm_rdata
);
  logic [15:0] dx [0:65535];
  logic [15:0] dy [0:65535];
  logic [23:0] mx [0:65535];
  logic [23:0] my [0:65535];
  logic [15:0] da;
  logic [15:0] ma;
  logic        ds;
  logic        ms;
  ////////////////////////////////////////////////////////////////////////////
  // cleared so that the polled words read as known values from the start
  initial begin
    for (int i = 0; i < 65536; i++) begin
      dx[i] = 16'h0000;
      dy[i] = 16'h0000;
      mx[i] = 24'h000000;
      my[i] = 24'h000000;
    end
  end
  // registered address: data is good on the second edge after a change
  always @(posedge core_clk) begin
    da <= dp_i.addr;
    ds <= dp_i.xsel;
    ma <= cm_i.addr;
    ms <= cm_i.xsel;
    if (dp_i.we && dp_i.xsel) dx[dp_i.addr] <= dp_i.wdata;
    if (dp_i.we && !dp_i.xsel) dy[dp_i.addr] <= dp_i.wdata;
    if (cm_i.we && cm_i.xsel) mx[cm_i.addr] <= cm_i.wdata;
    if (cm_i.we && !cm_i.xsel) my[cm_i.addr] <= cm_i.wdata;
  end
  assign dp_rdata = ds ? dx[da] : dy[da];
  assign cm_rdata = ms ? mx[ma] : my[ma];
  ////////////////////////////////////////////////////////////////////////////
  // host port: upper half lives in the X word, lower half in the Y word
  task automatic hw(input logic x, input logic [15:0] a,
                    input logic [15:0] d);
    if (x) dx[a] = d;
    else dy[a] = d;
  endtask
  function automatic logic [15:0] hr(input logic x, input logic [15:0] a);
    return x ? dx[a] : dy[a];
  endfunction
  task automatic cw(input logic x, input logic [15:0] a,
                    input logic [23:0] d);
    if (x) mx[a] = d;
    else my[a] = d;
  endtask
  function automatic logic [23:0] cr(input logic x, input logic [15:0] a);
    return x ? mx[a] : my[a];
  endfunction
endmodule

/* tb/tb_dbvx_exchange.sv */
// self-checking bench for the background variable exchange engine
`timescale 1ns/1ps
module tb_dbvx_exchange;
  logic                   core_clk;
  logic                   arst_n;
  logic                   multi_user;
  logic [15:0]            servo_timer;
  logic [15:0]            dp_rdata;
  logic [23:0]            cm_rdata;
  dbvx_pkg::dbvx_dp_req_t dp_o;
  dbvx_pkg::dbvx_cm_req_t cm_o;
  logic                   busy;
  int                     err_total;
  int                     n_compared;

  dbvx_exchange dut (.core_clk(core_clk), .arst_n(arst_n),
    .multi_user(multi_user), .servo_timer(servo_timer),
    .dp_rdata(dp_rdata), .cm_rdata(cm_rdata), .dp_o(dp_o), .cm_o(cm_o),
    .busy(busy));
  dbvx_host_model u_host (.core_clk(core_clk), .dp_i(dp_o), .cm_i(cm_o),
    .dp_rdata(dp_rdata), .cm_rdata(cm_rdata));

  always #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask
  // polls a dual-port word; the device may take long, but never forever
  task automatic wait_dp(input logic x, input logic [15:0] a,
                         input logic [15:0] m, input logic [15:0] v);
    int n;
    n = 0;
    while ((u_host.hr(x, a) & m) !== v && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    if ((u_host.hr(x, a) & m) !== v) begin
      check("wait_bound", 32'h00000001, 32'h00000000);
      results();
    end
  endtask
  task automatic chk_pair(input string nm, input logic [15:0] a,
                          input logic [31:0] e);
    check(nm, {u_host.hr(1'h1, a), u_host.hr(1'h0, a)}, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic do_wr(input logic [15:0] s, input logic [15:0] ctl,
                       input logic [15:0] ya, input logic [31:0] d1,
                       input logic [31:0] d2, input logic tx,
                       input logic [15:0] ta, input logic [23:0] pre,
                       input logic [23:0] e);
    u_host.cw(tx, ta, pre);
    u_host.hw(1'h1, s, ctl);
    u_host.hw(1'h0, s, ya);
    u_host.hw(1'h1, s + 16'h0001, d1[31:16]);
    u_host.hw(1'h0, s + 16'h0001, d1[15:0]);
    u_host.hw(1'h1, s + 16'h0002, d2[31:16]);
    u_host.hw(1'h0, s + 16'h0002, d2[15:0]);
    u_host.hw(1'h1, 16'hD1F5, s);
    u_host.hw(1'h0, 16'hD1F5, 16'h0001);
    wait_dp(1'h0, 16'hD1F5, 16'hFFFF, 16'h0000);
    check("wr_target", {8'h00, u_host.cr(tx, ta)}, {8'h00, e});
  endtask
  task automatic t_write;
    u_host.cw(1'h0, 16'h9FFF, 24'h001000);
    // width 8 at offset 4: the data is shifted up into the field, so a
    // lost shift or a wrong width shows in the merged word
    do_wr(16'hD240, 16'h0440, 16'h0100, 32'h000000AB, 32'h0,
          1'h0, 16'h0100, 24'hFFFFFF, 24'hFFFABF);
    do_wr(16'hD243, 16'h0001, 16'h0200, 32'h00123456,
          32'h00ABCDEF, 1'h1, 16'h0200, 24'h000000, 24'hABCDEF);
    check("wr_long_y", {8'h00, u_host.cr(1'h0, 16'h0200)},
          32'h123456);
    do_wr(16'hDFFB, 16'h0002, 16'h0300, 32'h00C0FFEE, 32'h0,
          1'h1, 16'h0300, 24'h555555, 24'hC0FFEE);
    do_wr(16'hD246, 16'h0004, 16'h0005, 32'h00000042, 32'h0,
          1'h0, 16'h1005, 24'h777777, 24'h000042);
    do_wr(16'hD249, 16'h0006, 16'h0006, 32'h0000BEEF, 32'h0,
          1'h1, 16'h1006, 24'h777777, 24'h00BEEF);
    do_wr(16'hD24C, 16'h2000, 16'h0400, 32'h00999999, 32'h0,
          1'h0, 16'h0400, 24'h111111, 24'h111111);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_read;
    servo_timer = 16'h4321;
    u_host.cw(1'h0, 16'h0500, 24'hABCDEF);
    u_host.cw(1'h0, 16'h0501, 24'h123456);
    u_host.cw(1'h1, 16'h0501, 24'h654321);
    u_host.cw(1'h1, 16'h0502, 24'h0F0F0F);
    u_host.cw(1'h0, 16'h1003, 24'h000111);
    u_host.cw(1'h1, 16'h1003, 24'h000222);
    for (int i = 0; i < 4; i++) begin
      u_host.hw(1'h1, 16'hD200 + 16'(i), (i == 3) ? 16'h0004 : 16'(i));
      u_host.hw(1'h0, 16'hD200 + 16'(i),
                (i == 3) ? 16'h0003 : 16'h0500 + 16'(i));
    end
    u_host.hw(1'h0, 16'hD20A, 16'hBEEF);
    u_host.hw(1'h0, 16'hD1FB, 16'h0004);
    u_host.hw(1'h1, 16'hD1FB, 16'hD200);
    u_host.hw(1'h0, 16'hD1FA, 16'h0000);
    wait_dp(1'h0, 16'hD1FA, 16'h0001, 16'h0001);
    check("timer_word", {16'h0, u_host.hr(1'h1, 16'hD1FA)},
          32'h4321);
    chk_pair("rd_y", 16'hD204, 32'h00ABCDEF);
    chk_pair("rd_long_lo", 16'hD205, 32'h00123456);
    chk_pair("rd_long_hi", 16'hD206, 32'h00654321);
    chk_pair("rd_x", 16'hD207, 32'h000F0F0F);
    chk_pair("rd_blk_lo", 16'hD208, 32'h00000111);
    chk_pair("rd_blk_hi", 16'hD209, 32'h00000222);
    check("past_count", {16'h0, u_host.hr(1'h0, 16'hD20A)},
          32'hBEEF);
    // while ready stands the buffer must not be refreshed
    u_host.cw(1'h0, 16'h0500, 24'h000777);
    repeat (300) @(negedge core_clk);
    chk_pair("rd_held", 16'hD204, 32'h00ABCDEF);
    u_host.hw(1'h0, 16'hD1FA, 16'h0000);
    wait_dp(1'h0, 16'hD1FA, 16'h0001, 16'h0001);
    chk_pair("rd_again", 16'hD204, 32'h00000777);
  endtask
  task automatic t_multi;
    for (int i = 0; i < 4; i++) begin
      u_host.hw(1'h1, 16'hD200 + 16'(i), u_host.hr(1'h1, 16'hD200 + 16'(i))
                | 16'h8000);
    end
    multi_user = 1'h1;
    u_host.hw(1'h0, 16'hD1FA, 16'h0000);
    u_host.cw(1'h0, 16'h0500, 24'h000555);
    u_host.cw(1'h1, 16'h0502, 24'h000666);
    u_host.hw(1'h1, 16'hD200, 16'h0000);
    wait_dp(1'h1, 16'hD200, 16'h8000, 16'h8000);
    chk_pair("mu_fresh", 16'hD204, 32'h00000555);
    chk_pair("mu_skip", 16'hD207, 32'h000F0F0F);
    check("mu_no_rdy", {16'h0, u_host.hr(1'h0, 16'hD1FA)}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    arst_n = 1'h0;
    multi_user = 1'h0;
    servo_timer = 16'h0000;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(negedge core_clk);
    check("rst_busy", {31'h0, busy}, 32'h0);
    check("rst_dp_we", {31'h0, dp_o.we}, 32'h0);
    arst_n = 1'h1;
    @(negedge core_clk);
    // busy trails the state by one edge, so it rises on the second one
    @(negedge core_clk);
    check("busy_run", {31'h0, busy}, 32'h1);
    t_write();
    t_read();
    t_multi();
    results();
  end
endmodule
